// >>> hdl/csbd_pkg.sv
package csbd_pkg;
    localparam int NUM_BANKS = 4;
    localparam int MASK_BITS = 17;
    localparam int MASK_LSB = 15;
    localparam int WAIT_W = 5;
    localparam logic [4:0] WAIT_MAX = 5'h1E;
    localparam logic [2:0] EXT_MASTER_TYPE = 3'h4;
    localparam logic [1:0] PS_32 = 2'h0;
    localparam logic [1:0] PS_8 = 2'h1;
    localparam logic [1:0] PS_16 = 2'h2;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [3:0] BEATS_SHORT = 4'h4;
    localparam logic [3:0] BEATS_LONG = 4'h8;
    localparam logic [2:0] BEAT_LAST_IN_LINE = 3'h7;
    localparam logic [5:0] BASE_CYCLES = 6'h2;
    localparam logic [3:0] STRB_IDLE = 4'hF;
    localparam logic [NUM_BANKS-1:0] CS_IDLE = 4'hF;
    localparam logic [3:0] WPE_RESET = 4'h0;
    localparam logic BOOT_VALID_RESET = 1'b1;
    typedef enum logic [1:0] {
        CSBD_IDLE,
        CSBD_WAIT,
        CSBD_EXT,
        CSBD_BDONE
    } csbd_state_e;
endpackage : csbd_pkg

// >>> hdl/csbd_match.sv
`timescale 1ns/1ps
module csbd_match (
    input wire logic [31:0] addr_i,
    input wire logic [2:0] atype_i,
    input wire logic [31:0] base_i,
    input wire logic [16:0] amask_i,
    input wire logic [2:0] at_val_i,
    input wire logic [2:0] at_mask_i,
    input wire logic valid_i,
    output logic hit_o
);
    logic addr_eq;
    logic type_eq;
    always_comb begin
        // low 15 bits never compared: 32 Kbyte smallest block
        addr_eq = (((addr_i[31:csbd_pkg::MASK_LSB] ^
                     base_i[31:csbd_pkg::MASK_LSB]) & amask_i) ==
                   17'h0);
        // zero mask means any type matches
        type_eq = (((atype_i ^ at_val_i) & at_mask_i) == 3'h0);
        hit_o = valid_i && addr_eq && type_eq;
    end
endmodule : csbd_match

// >>> hdl/csbd_top.sv
`timescale 1ns/1ps
module csbd_top (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic req_i,
    input wire logic mem_transfer_start_n_i,
    input wire logic ext_master_i,
    input wire logic [31:0] addr_i,
    input wire logic [2:0] atype_i,
    input wire logic rd_wr_n_i,
    input wire logic [1:0] size_i,
    input wire logic burst_i,
    input wire logic dual_map_hit_i,
    input wire logic burst_en_i,
    input wire logic late_burst_continue_strobe_i,
    input wire logic burst_continue_strobe_n_i,
    input wire logic transfer_ack_n_i,
    input wire logic transfer_error_ack_n_i,
    input wire logic wpe_clear_i,
    input wire logic [127:0] bank_base_reg_i,
    input wire logic [67:0] addr_mask_i,
    input wire logic [11:0] address_type_value_i,
    input wire logic [11:0] address_type_mask_i,
    input wire logic [3:0] bank_valid_i,
    input wire logic [7:0] port_size_field_i,
    input wire logic [3:0] write_protect_i,
    input wire logic [3:0] no_burst_flag_i,
    input wire logic [3:0] burst_size_sel_i,
    input wire logic [19:0] wait_count_field_i,
    input wire logic [19:0] burst_wait_field_i,
    input wire logic [3:0] relaxed_timing_i,
    input wire logic [3:0] external_ack_select_i,
    output logic [3:0] chip_sel_n_o,
    output logic [3:0] write_byte_strobe_n_o,
    output logic oe_n_o,
    output logic int_ack_o,
    output logic busy_o,
    output logic no_match_o,
    output logic size_error_o,
    output logic burst_continue_strobe_o,
    output logic [1:0] active_bank_o,
    output logic [3:0] mem_status_reg_o
);
    localparam int NB = csbd_pkg::NUM_BANKS;

    // pins pass two flops; bit 0 start, 1 burst, 2 ack, 3 error
    logic [3:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;

    csbd_pkg::csbd_state_e state_r, state_nxt;
    logic [3:0] cs_n_r, cs_n_nxt;
    logic [3:0] we_n_r, we_n_nxt;
    logic oe_n_r, oe_n_nxt;
    logic ack_r, ack_nxt;
    logic nomatch_r, nomatch_nxt;
    logic szerr_r, szerr_nxt;
    logic burst_continue_strobe_r, burst_continue_strobe_nxt;
    logic [1:0] bank_r, bank_nxt;
    logic [3:0] wpe_r, wpe_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [3:0] beats_r, beats_nxt;
    logic [2:0] word_r, word_nxt;
    logic burst_r, burst_nxt;
    logic busy_r, busy_nxt;

    logic [2:0] eff_type;
    logic [NB-1:0] hit;
    logic any_hit;
    logic [1:0] sel;
    logic start;
    logic sel_burst;
    logic size_ok;
    logic [5:0] wait_cyc;
    logic [5:0] bwait_cyc;

    function automatic logic size_allowed(input logic [1:0] ps,
                                          input logic [1:0] sz,
                                          input logic [1:0] a);
        logic ok;
        ok = 1'b0;
        case (ps)
            csbd_pkg::PS_8: ok = (sz == csbd_pkg::SIZE_BYTE);
            csbd_pkg::PS_16: ok = (sz == csbd_pkg::SIZE_BYTE) ||
                              (sz == csbd_pkg::SIZE_HALF && !a[1]);
            default: ok = (sz == csbd_pkg::SIZE_BYTE) ||
                          (sz == csbd_pkg::SIZE_HALF && !a[0]) ||
                          (sz == csbd_pkg::SIZE_WORD && a == 2'h0);
        endcase
        return ok;
    endfunction : size_allowed

    function automatic logic [3:0] lanes(input logic [1:0] sz,
                                         input logic [1:0] a);
        logic [3:0] l;
        l = 4'h0;
        case (sz)
            csbd_pkg::SIZE_BYTE: l = 4'h8 >> a;
            csbd_pkg::SIZE_HALF: l = a[1] ? 4'h3 : 4'hC;
            default: l = 4'hF;
        endcase
        return l;
    endfunction : lanes

    function automatic logic [5:0] waits(input logic [4:0] w,
                                         input logic rlx);
        logic [4:0] c;
        c = (w > csbd_pkg::WAIT_MAX) ? csbd_pkg::WAIT_MAX : w;
        return rlx ? {c, 1'b0} : {1'b0, c};
    endfunction : waits

    // external master requests see type 100
    assign eff_type = ext_master_i ? csbd_pkg::EXT_MASTER_TYPE
                                   : atype_i;

    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_bank
            logic bank_ok;
            // boot bank valid out of reset via bank_valid strap tie
            assign bank_ok = bank_valid_i[g];
            csbd_match u_match (
                .addr_i(addr_i),
                .atype_i(eff_type),
                .base_i(bank_base_reg_i[32*g +: 32]),
                .amask_i(addr_mask_i[17*g +: 17]),
                .at_val_i(address_type_value_i[3*g +: 3]),
                .at_mask_i(address_type_mask_i[3*g +: 3]),
                .valid_i(bank_ok),
                .hit_o(hit[g])
            );
        end
    endgenerate

    always_comb begin
        // lowest bank wins; dual mapping hides all banks
        sel = 2'h0;
        if (hit[0]) begin
            sel = 2'h0;
        end else if (hit[1]) begin
            sel = 2'h1;
        end else if (hit[2]) begin
            sel = 2'h2;
        end else begin
            sel = 2'h3;
        end
        any_hit = (|hit) && !dual_map_hit_i;
    end

    // internal request or other-bus transfer start
    assign start = req_i || !sync2_r[0];
    assign size_ok = size_allowed(port_size_field_i[2*sel +: 2], size_i,
                                  addr_i[1:0]);
    assign sel_burst = burst_i && rd_wr_n_i &&
                       !no_burst_flag_i[sel];
    assign wait_cyc = waits(wait_count_field_i[5*sel +: 5],
                            relaxed_timing_i[sel]);
    assign bwait_cyc = waits(burst_wait_field_i[5*bank_r +: 5],
                             relaxed_timing_i[bank_r]);

    always_comb begin
        sync1_nxt = {transfer_error_ack_n_i, transfer_ack_n_i,
                     burst_continue_strobe_n_i, mem_transfer_start_n_i};
        sync2_nxt = sync1_r;
    end

    always_comb begin
        state_nxt = state_r;
        cs_n_nxt = cs_n_r;
        we_n_nxt = we_n_r;
        oe_n_nxt = oe_n_r;
        ack_nxt = 1'b0;
        nomatch_nxt = nomatch_r;
        szerr_nxt = szerr_r;
        burst_continue_strobe_nxt = burst_continue_strobe_r;
        bank_nxt = bank_r;
        wpe_nxt = wpe_r & ~{4{wpe_clear_i}};
        cnt_nxt = cnt_r;
        beats_nxt = beats_r;
        word_nxt = word_r;
        burst_nxt = burst_r;
        case (state_r)
            csbd_pkg::CSBD_IDLE: begin
                if (start) begin
                    nomatch_nxt = 1'b0;
                    szerr_nxt = 1'b0;
                    if (any_hit && !rd_wr_n_i && write_protect_i[sel]) begin
                        // set beats clear in same cycle
                        wpe_nxt[sel] = 1'b1;
                        nomatch_nxt = 1'b1;
                    end else if (!any_hit) begin
                        // bus interface runs the cycle, bursts too
                        nomatch_nxt = 1'b1;
                    end else if (!size_ok) begin
                        szerr_nxt = 1'b1;
                    end else begin
                        bank_nxt = sel;
                        cs_n_nxt = ~(4'h1 << sel);
                        oe_n_nxt = !rd_wr_n_i;
                        we_n_nxt = rd_wr_n_i ? csbd_pkg::STRB_IDLE
                                   : ~lanes(size_i, addr_i[1:0]);
                        burst_nxt = sel_burst;
                        // bursts run eight beats only with burst_en_i and size select, else four
                        beats_nxt = (burst_en_i && burst_size_sel_i[sel])
                                    ? csbd_pkg::BEATS_LONG
                                    : csbd_pkg::BEATS_SHORT;
                        word_nxt = addr_i[4:2];
                        burst_continue_strobe_nxt = sel_burst && !late_burst_continue_strobe_i;
                        cnt_nxt = csbd_pkg::BASE_CYCLES - 6'h1 + wait_cyc;
                        state_nxt = external_ack_select_i[sel]
                                    ? csbd_pkg::CSBD_EXT
                                    : csbd_pkg::CSBD_WAIT;
                    end
                end
            end
            csbd_pkg::CSBD_WAIT: begin
                // strobes held across beats until the access terminates
                if (!sync2_r[3]) begin
                    state_nxt = csbd_pkg::CSBD_BDONE;
                end else if (cnt_r > 6'h1) begin
                    cnt_nxt = cnt_r - 6'h1;
                    if (burst_r && late_burst_continue_strobe_i) begin
                        burst_continue_strobe_nxt = 1'b1;
                    end
                end else begin
                    ack_nxt = 1'b1;
                    beats_nxt = beats_r - 4'h1;
                    word_nxt = word_r + 3'h1;
                    // external master ends burst with its own strobe
                    if (burst_r && beats_r > 4'h1 &&
                        word_r != csbd_pkg::BEAT_LAST_IN_LINE &&
                        !(ext_master_i && sync2_r[1])) begin
                        cnt_nxt = bwait_cyc + 6'h1;
                    end else begin
                        state_nxt = csbd_pkg::CSBD_BDONE;
                    end
                end
            end
            csbd_pkg::CSBD_EXT: begin
                // device sets the wait states with its acknowledge
                if (!sync2_r[2] || !sync2_r[3]) begin
                    state_nxt = csbd_pkg::CSBD_BDONE;
                end
            end
            csbd_pkg::CSBD_BDONE: begin
                cs_n_nxt = csbd_pkg::CS_IDLE;
                we_n_nxt = csbd_pkg::STRB_IDLE;
                oe_n_nxt = 1'b1;
                burst_continue_strobe_nxt = 1'b0;
                burst_nxt = 1'b0;
                state_nxt = csbd_pkg::CSBD_IDLE;
            end
            default: state_nxt = csbd_pkg::CSBD_IDLE;
        endcase
        busy_nxt = (state_nxt != csbd_pkg::CSBD_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sync1_r <= 4'hF;
            sync2_r <= 4'hF;
            state_r <= csbd_pkg::CSBD_IDLE;
            cs_n_r <= csbd_pkg::CS_IDLE;
            we_n_r <= csbd_pkg::STRB_IDLE;
            oe_n_r <= 1'b1;
            ack_r <= 1'b0;
            nomatch_r <= 1'b0;
            szerr_r <= 1'b0;
            burst_continue_strobe_r <= 1'b0;
            bank_r <= 2'h0;
            wpe_r <= csbd_pkg::WPE_RESET;
            cnt_r <= 6'h0;
            beats_r <= 4'h0;
            word_r <= 3'h0;
            burst_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            state_r <= state_nxt;
            cs_n_r <= cs_n_nxt;
            we_n_r <= we_n_nxt;
            oe_n_r <= oe_n_nxt;
            ack_r <= ack_nxt;
            nomatch_r <= nomatch_nxt;
            szerr_r <= szerr_nxt;
            burst_continue_strobe_r <= burst_continue_strobe_nxt;
            bank_r <= bank_nxt;
            wpe_r <= wpe_nxt;
            cnt_r <= cnt_nxt;
            beats_r <= beats_nxt;
            word_r <= word_nxt;
            burst_r <= burst_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign chip_sel_n_o = cs_n_r;
    assign write_byte_strobe_n_o = we_n_r;
    assign oe_n_o = oe_n_r;
    assign int_ack_o = ack_r;
    assign busy_o = busy_r;
    assign no_match_o = nomatch_r;
    assign size_error_o = szerr_r;
    assign burst_continue_strobe_o = burst_continue_strobe_r;
    assign active_bank_o = bank_r;
    assign mem_status_reg_o = wpe_r;
endmodule : csbd_top

// >>> test/csbd_assertions.sv
`timescale 1ns/1ps
module csbd_assertions (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic transfer_ack_n_i,
    input wire logic wpe_clear_i,
    input wire logic burst_i,
    input wire logic [19:0] wait_count_field_i,
    input wire logic [3:0] relaxed_timing_i,
    input wire logic [3:0] external_ack_select_i,
    input wire logic [3:0] chip_sel_n_o,
    input wire logic [3:0] write_byte_strobe_n_o,
    input wire logic oe_n_o,
    input wire logic int_ack_o,
    input wire logic busy_o,
    input wire logic no_match_o,
    input wire logic size_error_o,
    input wire logic burst_continue_strobe_o,
    input wire logic [1:0] active_bank_o,
    input wire logic [3:0] mem_status_reg_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic [1:0] ab;
    assign ab = active_bank_o;
    chk_one_select: assert property ($onehot0(~chip_sel_n_o))
        else $error("two selects low");
    chk_select_bank: assert property (chip_sel_n_o != 4'hF |->
        !chip_sel_n_o[ab]) else $error("select not of active bank");
    chk_refuse_idle: assert property (no_match_o || size_error_o |->
        chip_sel_n_o == 4'hF) else $error("select on refused access");
    chk_strobe_owned: assert property (chip_sel_n_o != 4'hF ||
        int_ack_o |-> busy_o) else $error("strobe outside access");
    chk_read_write: assert property (!oe_n_o |->
        write_byte_strobe_n_o == 4'hF) else $error("oe with write strobe");
    chk_burst_read: assert property (burst_continue_strobe_o |->
        write_byte_strobe_n_o == 4'hF) else $error("burst on write");
    // zero waits only; longer counts are timed by the bench monitor
    chk_zero_wait: assert property ($fell(&chip_sel_n_o) &&
        wait_count_field_i[ab*5 +: 5] == 5'h0 && !relaxed_timing_i[ab] &&
        !external_ack_select_i[ab] && !burst_i |=> int_ack_o)
        else $error("zero wait access not two cycles");
    chk_ext_wait: assert property (busy_o && external_ack_select_i[ab] &&
        $past(transfer_ack_n_i) && $past(transfer_ack_n_i, 2) &&
        $past(transfer_ack_n_i, 3) && $past(transfer_ack_n_i, 4) |->
        !int_ack_o) else $error("internal end with external ack");
    chk_status_sticky: assert property (!$past(wpe_clear_i) &&
        !$past(wpe_clear_i, 2) |-> (mem_status_reg_o &
        $past(mem_status_reg_o)) == $past(mem_status_reg_o))
        else $error("status bit lost");
endmodule : csbd_assertions

// >>> test/csbd_mem_model.sv
`timescale 1ns/1ps
module csbd_mem_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic cs_n_i,
    input wire logic [4:0] delay_i,
    output logic ack_n_o = 1'b1
);
    logic [4:0] cnt = 5'h0;
    // one ack per select, then waits for deselect
    always @(posedge clk_i) begin
        if (!nrst_i || cs_n_i) begin
            cnt <= 5'h0;
            ack_n_o <= 1'b1;
        end else begin
            if (cnt != 5'h1F) cnt <= cnt + 5'h1;
            ack_n_o <= (cnt != delay_i);
        end
    end
endmodule : csbd_mem_model

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct {
        logic [3:0] cs;
        logic oe;
        logic [3:0] we;
        logic bd;
        int cy;
    } csbd_note_s;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic req_i, mem_transfer_start_n_i, ext_master_i, rd_wr_n_i, burst_i;
    logic dual_map_hit_i, burst_en_i, late_burst_continue_strobe_i, burst_continue_strobe_n_i;
    logic transfer_ack_n_i, transfer_error_ack_n_i, wpe_clear_i;
    logic [31:0] addr_i;
    logic [2:0] atype_i;
    logic [1:0] size_i, active_bank_o;
    logic [127:0] bank_base_reg_i;
    logic [67:0] addr_mask_i;
    logic [11:0] address_type_value_i, address_type_mask_i;
    logic [3:0] bank_valid_i, write_protect_i, no_burst_flag_i;
    logic [3:0] burst_size_sel_i, relaxed_timing_i, external_ack_select_i;
    logic [7:0] port_size_field_i;
    logic [19:0] wait_count_field_i, burst_wait_field_i;
    logic [3:0] chip_sel_n_o, write_byte_strobe_n_o, mem_status_reg_o;
    logic oe_n_o, int_ack_o, busy_o, no_match_o, size_error_o, burst_continue_strobe_o;
    int failures = 0;
    int total_checks = 0;
    int tn = 0;
    int cnt = 0;
    csbd_note_s exp_q[$];
    csbd_note_s m;
    always #10 clk_i = ~clk_i;
    csbd_top csbd_top_i (
        .clk_i, .nrst_i, .req_i, .mem_transfer_start_n_i, .ext_master_i,
        .addr_i, .atype_i, .rd_wr_n_i, .size_i, .burst_i, .dual_map_hit_i,
        .burst_en_i, .late_burst_continue_strobe_i, .burst_continue_strobe_n_i,
        .transfer_ack_n_i, .transfer_error_ack_n_i, .wpe_clear_i,
        .bank_base_reg_i, .addr_mask_i, .address_type_value_i,
        .address_type_mask_i, .bank_valid_i, .port_size_field_i,
        .write_protect_i, .no_burst_flag_i, .burst_size_sel_i,
        .wait_count_field_i, .burst_wait_field_i, .relaxed_timing_i,
        .external_ack_select_i, .chip_sel_n_o, .write_byte_strobe_n_o,
        .oe_n_o, .int_ack_o, .busy_o, .no_match_o, .size_error_o, .burst_continue_strobe_o,
        .active_bank_o, .mem_status_reg_o
    );
    csbd_mem_model csbd_mem_model_i (.clk_i, .nrst_i,
        .cs_n_i(chip_sel_n_o[3]), .delay_i(5'h0C),
        .ack_n_o(transfer_ack_n_i));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    function automatic logic [3:0] we_of(input logic [1:0] sz,
        input logic [1:0] a);
        if (sz == 2'h0) return ~(4'h8 >> a);
        if (sz == 2'h1) return a[1] ? 4'hC : 4'h3;
        return 4'h0;
    endfunction : we_of
    // bk 0..3 bank, 4 no match, 5 size refusal; bank 3 acks externally
    task automatic acc(input logic [31:0] a, input logic [2:0] at,
        input logic rd, input logic [1:0] sz, input logic em,
        input logic mem_transfer_start, input int bk, input int cy, input int nb);
        csbd_note_s n;
        int k;
        n.cs = (bk < 4) ? ~(4'h1 << bk) : 4'hF;
        n.oe = !rd;
        n.we = rd ? 4'hF : we_of(sz, a[1:0]);
        n.cy = cy;
        n.bd = burst_i || nb > 1;
        if (bk < 3) repeat (nb) exp_q.push_back(n);
        @(posedge clk_i) #1 {addr_i, atype_i, rd_wr_n_i} = {a, at, rd};
        {size_i, ext_master_i} = {sz, em};
        burst_i = burst_i || nb > 1;
        if (mem_transfer_start) mem_transfer_start_n_i = 1'b0;
        else req_i = 1'b1;
        @(posedge clk_i) #1 {req_i, mem_transfer_start_n_i} = 2'b01;
        k = 0;
        // strobe pin is synchronised, so the take may lag
        while (busy_o !== 1'b1 && k < 4) @(posedge clk_i) #1 k++;
        if (bk == 3) begin
            repeat (6) @(posedge clk_i);
            #1 chk(busy_o, 1'b1);
            chk(chip_sel_n_o, 4'h7);
        end
        while (busy_o !== 1'b0 && k < 300) @(posedge clk_i) #1 k++;
        repeat (2) @(posedge clk_i);
        #1 chk(no_match_o, bk == 4);
        chk(size_error_o, bk == 5);
        chk(chip_sel_n_o, 4'hF);
        chk(exp_q.size(), 0);
        burst_i = 1'b0;
        tn++;
        $display("test %0d done", tn);
    endtask : acc
    always @(negedge clk_i) begin
        if (chip_sel_n_o === 4'hF) cnt = 0;
        else cnt++;
        if (int_ack_o === 1'b1 &&
            external_ack_select_i[active_bank_o] !== 1'b1) begin
            if (exp_q.size() == 0) chk(1'b1, 1'b0);
            else begin
                m = exp_q.pop_front();
                chk(chip_sel_n_o, m.cs);
                chk(oe_n_o, m.oe);
                chk(write_byte_strobe_n_o, m.we);
                chk(burst_continue_strobe_o, m.bd);
                if (m.cy != -1) chk(cnt, m.cy);
            end
        end
    end
    initial begin
        #100000 failures++;
        complete_run;
    end
    initial begin
        int w;
        int s;
        int o;
        {req_i, ext_master_i, rd_wr_n_i, burst_i, dual_map_hit_i} = 5'h0;
        {late_burst_continue_strobe_i, wpe_clear_i, burst_en_i} = 3'h1;
        {mem_transfer_start_n_i, burst_continue_strobe_n_i} = 2'h3;
        {transfer_error_ack_n_i, addr_i, atype_i, size_i} = {1'b1, 37'h0};
        bank_base_reg_i = {32'h01000000, 32'h02000000, 32'h01000000, 32'h0};
        addr_mask_i = {17'h1FFFF, 17'h1FFFE, 17'h1FFFF, 17'h1FFFF};
        {address_type_value_i, address_type_mask_i} = {12'h020, 12'h038};
        {bank_valid_i, write_protect_i, no_burst_flag_i} = 12'hF4D;
        {burst_size_sel_i, relaxed_timing_i, external_ack_select_i} = 12'h048;
        port_size_field_i = {csbd_pkg::PS_32, csbd_pkg::PS_8,
            csbd_pkg::PS_32, csbd_pkg::PS_16};
        {wait_count_field_i, burst_wait_field_i} = {20'h00800, 20'h0};
        w = $urandom(32'h28F6);
        repeat (6) @(posedge clk_i);
        #1 nrst_i = 1'b1;
        acc(32'h10, 3'h1, 1, 2'h1, 0, 0, 0, 2, 1);
        acc(32'h01000004, 3'h4, 0, 2'h2, 0, 0, 1, 2, 1);
        acc(32'h01000006, 3'h0, 1, 2'h1, 1, 0, 1, 2, 1);
        acc(32'h01000008, 3'h1, 1, 2'h2, 0, 0, 3, 0, 1);
        acc(32'h02000000, 3'h0, 0, 2'h0, 0, 0, 4, 0, 1);
        chk(mem_status_reg_o, 4'h4);
        wpe_clear_i = 1'b1;
        @(posedge clk_i) #1 wpe_clear_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk(mem_status_reg_o, 4'h0);
        acc(32'h0200C001, 3'h0, 1, 2'h0, 0, 0, 2, 6, 1);
        acc(32'h0200C002, 3'h0, 1, 2'h1, 0, 0, 5, 0, 1);
        acc(32'h0, 3'h0, 1, 2'h2, 0, 0, 5, 0, 1);
        acc(32'h08000000, 3'h0, 1, 2'h2, 0, 0, 4, 0, 1);
        dual_map_hit_i = 1'b1;
        acc(32'h10, 3'h1, 1, 2'h0, 0, 0, 4, 0, 1);
        {dual_map_hit_i, bank_valid_i} = 5'h0D;
        acc(32'h01000004, 3'h4, 1, 2'h2, 0, 0, 3, 0, 1);
        bank_valid_i = 4'hF;
        acc(32'h10, 3'h1, 1, 2'h0, 0, 1, 0, 2, 1);
        acc(32'h01000010, 3'h4, 1, 2'h2, 0, 0, 1, -1, 4);
        // external master holds burst strobe low: full burst
        burst_continue_strobe_n_i = 1'b0;
        acc(32'h01000010, 3'h0, 1, 2'h2, 1, 0, 1, -1, 4);
        // strobe negated: burst must stop after one beat
        {burst_continue_strobe_n_i, burst_i} = 2'h3;
        acc(32'h01000010, 3'h0, 1, 2'h2, 1, 0, 1, 2, 1);
        for (int i = 0; i < 3; i++) begin
            w = (i == 0) ? 30 : $urandom % 31;
            wait_count_field_i[9:5] = w[4:0];
            s = $urandom % 3;
            o = $urandom % 4;
            o = (s == 2) ? 0 : (s == 1) ? (o & 2) : o;
            acc(32'h01000000 | o, 3'h4, $urandom % 2, s[1:0], 0, 0, 1,
                2 + w, 1);
        end
        {late_burst_continue_strobe_i, wait_count_field_i[9:5]} = 6'h21;
        acc(32'h01000010, 3'h4, 1, 2'h2, 0, 0, 1, -1, 4);
        complete_run;
    end
endmodule : tb_top
bind csbd_top csbd_assertions csbd_assertions_i (.clk_i, .nrst_i,
    .transfer_ack_n_i, .wpe_clear_i, .burst_i, .wait_count_field_i,
    .relaxed_timing_i, .external_ack_select_i, .chip_sel_n_o,
    .write_byte_strobe_n_o, .oe_n_o, .int_ack_o, .busy_o, .no_match_o,
    .size_error_o, .burst_continue_strobe_o, .active_bank_o, .mem_status_reg_o);
